// file: core/ctm_params.svh
// Register offsets, field positions, reset values and timing for the compact timer.
// Assumes a classic Wishbone slave with 32-bit data, one register per aligned word.
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH

`define CTM_OFS_CTRL0      8'h00
`define CTM_OFS_CTRL1      8'h04
`define CTM_OFS_CNT_LO     8'h08
`define CTM_OFS_CNT_HI     8'h0C
`define CTM_OFS_DUTY_LO    8'h10
`define CTM_OFS_DUTY_HI    8'h14
`define CTM_OFS_STATUS     8'h18
`define CTM_OFS_PINCTL     8'h1C

`define CTM_CTRL0_RESET    8'h00
`define CTM_CTRL1_RESET    8'h00
`define CTM_DUTY_RESET     10'h000

`define CTM_F_PAUSE        7
`define CTM_F_CLKSEL_HI    6
`define CTM_F_CLKSEL_LO    4
`define CTM_F_RUN          3
`define CTM_F_PERIOD_HI    2
`define CTM_F_PERIOD_LO    0

`define CTM_F_MODE_HI      7
`define CTM_F_MODE_LO      6
`define CTM_F_ACT_HI       5
`define CTM_F_ACT_LO       4
`define CTM_F_INIT         3
`define CTM_F_INV          2
`define CTM_F_SWAP         1
`define CTM_F_CLRSEL       0

`define CTM_DIV_SYS4       4
`define CTM_DIV_H16        16
`define CTM_DIV_H64        64
`define CTM_DIV_SUB        256

`endif

// file: core/ctm_pkg.sv
// Types shared by the compact timer design.
// Assumes the header ctm_params.svh is included where constants are needed.
package ctm_pkg;

	typedef enum logic [1:0] {
		CTM_MODE_COMPARE = 2'h0,
		CTM_MODE_UNDEF   = 2'h1,
		CTM_MODE_PWM     = 2'h2,
		CTM_MODE_TIMER   = 2'h3
	} ctm_mode_t;

	typedef struct packed {
		logic       count_pause;
		logic [2:0] count_clock_select;
		logic       timer_run_enable;
		logic [2:0] period_compare_bits;
	} ctm_ctrl0_t;

	typedef struct packed {
		ctm_mode_t  operating_mode;
		logic [1:0] pin_action;
		logic       output_initial_level;
		logic       output_invert;
		logic       duty_period_swap;
		logic       clear_source_select;
	} ctm_ctrl1_t;

	typedef struct packed {
		logic duty_match;
		logic period_match;
	} ctm_irq_t;

endpackage

// file: core/ctm_timer.sv
// Compact 10-bit timer with period and duty comparators, behind classic Wishbone.
// Assumes one clock, synchronous inputs, and software that keeps the byte access order.
//
// Behaviour
// RL1 - Two interrupt requests, one per comparator, pulse on each comparator match.
// RL2 - A comparator match can clear the counter and change the output pin.
// RL3 - External clock pin advances the counter on rising or falling edge, as selected.
// RL4 - Compare mode: match sets pin high, low, toggles it, or leaves it.
// RL5 - The same output pin carries the PWM waveform in PWM mode.
// RL6 - Software routes the shared pin to the timer before relying on it.
// RL7 - Writing duty low byte only fills the holding buffer.
// RL8 - Writing duty high byte updates it and copies buffer into low byte.
// RL9 - Reading counter or duty high byte latches live low byte into buffer.
// RL10 - Reading counter or duty low byte returns the holding buffer.
// RL11 - Software writes low then high, reads high then low.
// RL12 - Core is a 10-bit up-counter on selected internal or external clock.
// RL13 - Period compare is 3 bits against top counter bits; duty is 10 bits.
// RL14 - Counter only cleared by software through run enable going low to high.
// RL15 - Counter clears on overflow or selected match, raising the interrupt.
// RL16 - Modes are compare-match output, timer/counter and PWM output.
// RL17 - Count is a read-only register pair; duty is a read/write pair.
// RL18 - Counter high byte shows bits 9 and 8; bits 7 to 2 read zero.
// RL19 - Period value zero gives no early clear; counter overflows at maximum.
// RL20 - Clear select 0 uses period match, 1 uses duty match.
// RL21 - Enabled and not paused, count by one per active edge, else hold.
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`include "ctm_params.svh"

module ctm_timer #(
	parameter int CNT_W   = 10,
	parameter int DIV_SUB = `CTM_DIV_SUB
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rstn,
	// Wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	output logic                       wb_err_o,
	// Clock sources
	input  wire logic                  high_clk_tick,
	input  wire logic                  sub_clk_tick,
	input  wire logic                  external_count_clock_pin,
	// Timer pin and events
	output logic                       timer_output_pin,
	output logic                       timer_output_pin_oe,
	output ctm_pkg::ctm_irq_t          irq_pulse
);

	initial begin
		if (CNT_W != 10) $error("ctm_timer supports only a 10-bit counter");
		// Sub divider counter is 8 bits wide
		if (DIV_SUB < 1 || DIV_SUB > 256) $error("ctm_timer sub divider must be 1 to 256");
	end

	ctm_pkg::ctm_ctrl0_t ctrl0_q;
	ctm_pkg::ctm_ctrl1_t ctrl1_q;
	logic [9:0]  duty_q;
	logic [7:0]  hold_buf_q;
	logic [9:0]  count_q;
	logic        out_q;
	logic        ext_pin_q;
	logic        run_q;
	logic [5:0]  div_q;
	logic [7:0]  sub_div_q;
	logic [1:0]  sticky_q;
	logic        pin_route_q;

	// Bus decode; answer in the cycle after the strobe, one cycle long
	logic        req;
	logic        wr;
	logic        rd;
	logic        mapped;
	assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wr     = req && wb_we_i && wb_sel_i[0] && mapped;
	assign rd     = req && !wb_we_i && mapped;

	always_comb begin
		unique case (wb_adr_i)
			`CTM_OFS_CTRL0, `CTM_OFS_CTRL1, `CTM_OFS_CNT_LO, `CTM_OFS_CNT_HI,
			`CTM_OFS_DUTY_LO, `CTM_OFS_DUTY_HI, `CTM_OFS_STATUS,
			`CTM_OFS_PINCTL: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			wb_ack_o <= req && mapped;
			wb_err_o <= req && !mapped;
		end
	end

	// Control registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl0_q     <= `CTM_CTRL0_RESET;
			ctrl1_q     <= `CTM_CTRL1_RESET;
			pin_route_q <= 1'b0;
		end else if (wr) begin
			if (wb_adr_i == `CTM_OFS_CTRL0) ctrl0_q <= wb_dat_i[7:0];
			if (wb_adr_i == `CTM_OFS_CTRL1) ctrl1_q <= wb_dat_i[7:0];
			if (wb_adr_i == `CTM_OFS_PINCTL) pin_route_q <= wb_dat_i[0]; // RL6
		end
	end

	// Duty pair and shared holding buffer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			duty_q     <= `CTM_DUTY_RESET;
			hold_buf_q <= 8'h00;
		end else begin
			if (wr && wb_adr_i == `CTM_OFS_DUTY_LO) begin
				hold_buf_q <= wb_dat_i[7:0]; // RL7
			end
			if (wr && wb_adr_i == `CTM_OFS_DUTY_HI) begin
				duty_q <= {wb_dat_i[1:0], hold_buf_q}; // RL8
			end
			if (rd && wb_adr_i == `CTM_OFS_CNT_HI) begin
				hold_buf_q <= count_q[7:0]; // RL9
			end
			if (rd && wb_adr_i == `CTM_OFS_DUTY_HI) begin
				hold_buf_q <= duty_q[7:0]; // RL9
			end
		end
	end

	// Read data is registered with the ack
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd) begin
			unique case (wb_adr_i)
				`CTM_OFS_CTRL0:   wb_dat_o <= {24'h00_0000, ctrl0_q};
				`CTM_OFS_CTRL1:   wb_dat_o <= {24'h00_0000, ctrl1_q};
				`CTM_OFS_CNT_LO:  wb_dat_o <= {24'h00_0000, hold_buf_q};        // RL10
				`CTM_OFS_CNT_HI:  wb_dat_o <= {30'h0000_0000, count_q[9:8]};  // RL18
				`CTM_OFS_DUTY_LO: wb_dat_o <= {24'h00_0000, hold_buf_q};        // RL10
				`CTM_OFS_DUTY_HI: wb_dat_o <= {30'h0000_0000, duty_q[9:8]};   // RL17
				`CTM_OFS_STATUS:  wb_dat_o <= {30'h0000_0000, sticky_q};
				default:          wb_dat_o <= {31'h0000_0000, pin_route_q};
			endcase
		end
	end

	// Internal clock dividers; every slower rate is a one-cycle tick
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_q     <= 6'h00;
			sub_div_q <= 8'h00;
		end else begin
			if (high_clk_tick) div_q <= div_q + 6'h01;
			if (sub_clk_tick) begin
				if (sub_div_q == 8'(DIV_SUB - 1)) sub_div_q <= 8'h00;
				else sub_div_q <= sub_div_q + 8'h01;
			end
		end
	end

	logic sys_div4_tick;
	logic sys_cnt_q;
	logic [1:0] sys4_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sys4_q    <= 2'h0;
			sys_cnt_q <= 1'b0;
		end else begin
			sys4_q    <= sys4_q + 2'h1;
			sys_cnt_q <= 1'b1;
		end
	end
	assign sys_div4_tick = sys_cnt_q && (sys4_q == 2'h3);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) ext_pin_q <= 1'b0;
		else ext_pin_q <= external_count_clock_pin;
	end

	// Selected count tick
	logic tick;
	always_comb begin
		unique case (ctrl0_q.count_clock_select)
			3'h0: tick = sys_div4_tick;
			3'h1: tick = 1'b1;
			3'h2: tick = high_clk_tick && (div_q[3:0] == 4'hF);
			3'h3: tick = high_clk_tick && (div_q == 6'h3F);
			3'h4, 3'h5: tick = sub_clk_tick && (sub_div_q == 8'(DIV_SUB - 1));
			3'h6: tick = external_count_clock_pin && !ext_pin_q;  // RL3
			3'h7: tick = !external_count_clock_pin && ext_pin_q;  // RL3
		endcase
	end

	// Comparators
	logic per_match;
	logic duty_match;
	logic ovf;
	logic clear_hit;
	logic adv;
	assign adv        = ctrl0_q.timer_run_enable && !ctrl0_q.count_pause && tick; // RL21
	assign per_match  = (ctrl0_q.period_compare_bits != 3'h0)
			&& (count_q[9:7] == ctrl0_q.period_compare_bits); // RL13 RL19
	assign duty_match = (count_q == duty_q); // RL13
	assign ovf        = (count_q == 10'h3FF);
	assign clear_hit  = ctrl1_q.clear_source_select ? duty_match : per_match; // RL20

	// Counter; only software path is clear on run enable rising
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_q <= 10'h000;
			run_q   <= 1'b0;
		end else begin
			run_q <= ctrl0_q.timer_run_enable;
			if (ctrl0_q.timer_run_enable && !run_q) begin
				count_q <= 10'h000; // RL14
			end else if (adv) begin
				if (ovf || clear_hit) count_q <= 10'h000; // RL15 RL2
				else count_q <= count_q + 10'h001; // RL12
			end
		end
	end

	// Match events pulse one cycle after the counting tick that sees the match
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_pulse <= 2'h0;
		end else begin
			irq_pulse.duty_match   <= adv && duty_match; // RL1
			irq_pulse.period_match <= adv && (per_match
					|| (ovf && ctrl0_q.period_compare_bits == 3'h0)); // RL1 RL15
		end
	end

	// Sticky copy for polling; event set wins over write-one clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) sticky_q <= 2'h0;
		else if (wr && wb_adr_i == `CTM_OFS_STATUS) sticky_q <= (sticky_q & ~wb_dat_i[1:0]) | irq_pulse;
		else sticky_q <= sticky_q | irq_pulse;
	end

	// Output level: compare mode acts on duty match, PWM from compare, timer mode idle
	logic pwm_lvl;
	logic duty_ref_hit;
	assign duty_ref_hit = ctrl1_q.duty_period_swap
			? (count_q[9:7] < ctrl0_q.period_compare_bits)
			: (count_q < duty_q);
	always_comb begin
		unique case (ctrl1_q.pin_action)
			2'h0: pwm_lvl = 1'b0;
			2'h1: pwm_lvl = 1'b1;
			default: pwm_lvl = duty_ref_hit;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_q <= 1'b0;
		end else if (ctrl0_q.timer_run_enable && !run_q
				&& ctrl1_q.operating_mode == ctm_pkg::CTM_MODE_COMPARE) begin
			out_q <= ctrl1_q.output_initial_level;
		end else if (ctrl1_q.operating_mode == ctm_pkg::CTM_MODE_COMPARE) begin
			if (adv && duty_match) begin // RL2
				unique case (ctrl1_q.pin_action)
					2'h0: out_q <= out_q; // RL4
					2'h1: out_q <= 1'b0; // RL4
					2'h2: out_q <= 1'b1; // RL4
					2'h3: out_q <= !out_q; // RL4
				endcase
			end
		end else if (ctrl1_q.operating_mode == ctm_pkg::CTM_MODE_PWM) begin
			out_q <= ctrl1_q.output_initial_level ? pwm_lvl : !pwm_lvl; // RL5
		end
	end

	// Timer mode releases the pin; modes are fixed by the two mode bits
	assign timer_output_pin    = out_q ^ ctrl1_q.output_invert;
	assign timer_output_pin_oe = pin_route_q
			&& ctrl1_q.operating_mode != ctm_pkg::CTM_MODE_TIMER; // RL16

	a_run_rise_clear: assert property (@(posedge clk) disable iff (!rstn)
		(ctrl0_q.timer_run_enable && !run_q) |=> count_q == 10'h000) // RL14
		else $error("counter not cleared on run enable");

	a_count_step: assert property (@(posedge clk) disable iff (!rstn)
		(adv && !ovf && !clear_hit && !(ctrl0_q.timer_run_enable && !run_q))
		|=> count_q == $past(count_q) + 10'h001) // RL21
		else $error("counter did not step");

	a_hold_idle: assert property (@(posedge clk) disable iff (!rstn)
		(!adv && !(ctrl0_q.timer_run_enable && !run_q)) |=> $stable(count_q)) // RL21
		else $error("counter moved without tick");

	a_match_clear: assert property (@(posedge clk) disable iff (!rstn)
		(adv && (ovf || clear_hit)) |=> count_q == 10'h000) // RL15
		else $error("counter not cleared on match");

	a_duty_irq: assert property (@(posedge clk) disable iff (!rstn)
		(adv && duty_match) |=> irq_pulse.duty_match) // RL1
		else $error("duty event missing");

	a_period_zero: assert property (@(posedge clk) disable iff (!rstn)
		(ctrl0_q.period_compare_bits == 3'h0) |-> !per_match) // RL19
		else $error("period zero matched");

	sequence s_lo_write;
		wr && wb_adr_i == `CTM_OFS_DUTY_LO;
	endsequence
	a_lo_buffered: assert property (@(posedge clk) disable iff (!rstn)
		s_lo_write |=> $stable(duty_q) && hold_buf_q == $past(wb_dat_i[7:0])) // RL7
		else $error("low write reached duty");

	a_hi_commit: assert property (@(posedge clk) disable iff (!rstn)
		(wr && wb_adr_i == `CTM_OFS_DUTY_HI)
		|=> duty_q == {$past(wb_dat_i[1:0]), $past(hold_buf_q)}) // RL8
		else $error("high write did not commit");

	a_hi_latch: assert property (@(posedge clk) disable iff (!rstn)
		(rd && wb_adr_i == `CTM_OFS_CNT_HI)
		|=> hold_buf_q == $past(count_q[7:0]) && wb_dat_o[31:2] == 30'h0000_0000) // RL9
		else $error("high read did not latch");

	a_ext_edge: assert property (@(posedge clk) disable iff (!rstn)
		(ctrl0_q.count_clock_select == 3'h6 && tick) |-> $rose(external_count_clock_pin)) // RL3
		else $error("external tick without rising edge");

	a_toggle_out: assert property (@(posedge clk) disable iff (!rstn)
		(ctrl1_q.operating_mode == ctm_pkg::CTM_MODE_COMPARE && ctrl1_q.pin_action == 2'h3
		&& adv && duty_match && run_q) |=> out_q != $past(out_q)) // RL4
		else $error("output did not toggle");

	sequence s_run_rise;
		ctrl0_q.timer_run_enable && !run_q;
	endsequence
	sequence s_cmp_set;
		ctrl1_q.operating_mode == ctm_pkg::CTM_MODE_COMPARE && ctrl1_q.pin_action == 2'h2
		&& adv && duty_match && run_q;
	endsequence
	sequence s_cmp_clr;
		ctrl1_q.operating_mode == ctm_pkg::CTM_MODE_COMPARE && ctrl1_q.pin_action == 2'h1
		&& adv && duty_match && run_q;
	endsequence

	a_ack_pulse: assert property (@(posedge clk) disable iff (!rstn)
		wb_ack_o |=> !wb_ack_o) // RL17
		else $error("ack held longer than one cycle");

	a_bus_answer: assert property (@(posedge clk) disable iff (!rstn)
		req |=> (wb_ack_o || wb_err_o)) // RL17
		else $error("request not answered");

	a_timer_oe: assert property (@(posedge clk) disable iff (!rstn)
		(ctrl1_q.operating_mode == ctm_pkg::CTM_MODE_TIMER) |-> !timer_output_pin_oe) // RL16
		else $error("pin driven in timer mode");

	a_pin_set: assert property (@(posedge clk) disable iff (!rstn)
		s_cmp_set |=> out_q) // RL4
		else $error("output not set on match");

	a_pin_clear: assert property (@(posedge clk) disable iff (!rstn)
		s_cmp_clr |=> !out_q) // RL4
		else $error("output not cleared on match");

	a_run_init: assert property (@(posedge clk) disable iff (!rstn)
		s_run_rise ##0 (ctrl1_q.operating_mode == ctm_pkg::CTM_MODE_COMPARE)
		|=> out_q == $past(ctrl1_q.output_initial_level)) // RL4
		else $error("output not reloaded on run");

	a_pwm_level: assert property (@(posedge clk) disable iff (!rstn)
		(ctrl1_q.operating_mode == ctm_pkg::CTM_MODE_PWM && !(ctrl0_q.timer_run_enable && !run_q))
		|=> out_q == ($past(ctrl1_q.output_initial_level) ? $past(pwm_lvl) : !$past(pwm_lvl))) // RL5
		else $error("pwm level wrong");

	a_period_irq: assert property (@(posedge clk) disable iff (!rstn)
		(adv && per_match) |=> irq_pulse.period_match) // RL1
		else $error("period event missing");

	a_lo_read: assert property (@(posedge clk) disable iff (!rstn)
		(rd && wb_adr_i == `CTM_OFS_CNT_LO) |=> wb_dat_o == {24'h00_0000, $past(hold_buf_q)}) // RL10
		else $error("low read not from buffer");

	a_ext_fall: assert property (@(posedge clk) disable iff (!rstn)
		(ctrl0_q.count_clock_select == 3'h7 && tick) |-> $fell(external_count_clock_pin)) // RL3
		else $error("external tick without falling edge");

	a_sticky_set: assert property (@(posedge clk) disable iff (!rstn)
		irq_pulse.duty_match |=> sticky_q[1]) // RL1
		else $error("sticky duty flag lost");

endmodule

// file: tb/ctm_timer_tb.sv
// Self-checking bench for the compact timer, driven over classic Wishbone.
// Assumes the design sources and ctm_params.svh are on the include path.
`include "ctm_params.svh"

module ctm_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic              clk, rstn, cyc, stb, we, hi_t, sub_t, ext;
	logic [7:0]        adr;
	logic [31:0]       dat_w, dat_r, rdat, v1;
	logic              ack, err, rerr, pin, oe;
	ctm_pkg::ctm_irq_t irq;
	int                n_fail, comparisons, hits, edges, a;

	ctm_timer #(.CNT_W(10), .DIV_SUB(2)) dut (
		.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
		.wb_ack_o(ack), .wb_err_o(err), .high_clk_tick(hi_t), .sub_clk_tick(sub_t),
		.external_count_clock_pin(ext), .timer_output_pin(pin),
		.timer_output_pin_oe(oe), .irq_pulse(irq));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Tick sources kept moving so the prescalers never sit idle
	always @(posedge clk) begin
		hi_t <= ~hi_t;
		sub_t <= ~sub_t;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One classic cycle; request held until ack or err is sampled high
	task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		dat_w <= {24'h000000, d};
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (ack === 1'b1 || err === 1'b1) break;
		end
		if (i == 20) begin
			n_fail++;
			report_and_stop();
		end
		rdat = dat_r;
		rerr = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		bus(1'b1, ad, d);
	endtask

	task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
		bus(1'b0, ad, 8'h00);
		check("read data", rdat, {24'h000000, exp});
	endtask

	// Edges between two pulses of one request line; bounded both ways
	task automatic gap(input int b, input int exp);
		int t;
		for (t = 0; t < 3000 && irq[b] !== 1'b1; t++) @(posedge clk);
		@(posedge clk);
		for (t = 1; t < 3000 && irq[b] !== 1'b1; t++) @(posedge clk);
		check("irq gap", t, exp);
	endtask

	// Stop, reconfigure, restart: mode bits are only safe to change while off
	task automatic restart(input logic [7:0] c1, input logic [7:0] c0);
		wr(`CTM_OFS_CTRL0, c0 & 8'hF7);
		wr(`CTM_OFS_CTRL1, c1);
		wr(`CTM_OFS_CTRL0, c0);
	endtask

	task automatic watch(input int n);
		logic last;
		last = pin;
		hits = 0;
		edges = 0;
		repeat (n) begin
			@(posedge clk);
			hits += (pin === 1'b1);
			edges += (pin !== last);
			last = pin;
		end
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			ext <= 1'b1;
			repeat (3) @(posedge clk);
			ext <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask

	initial begin
		{rstn, cyc, stb, we, hi_t, sub_t, ext} = 7'h00;
		adr = 8'h00;
		dat_w = 32'h00000000;
		n_fail = 0;
		comparisons = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (a = 0; a < 32; a += 4) rdc(a[7:0], 8'h00);
		check("pin enable", oe, 1'b0);
		bus(1'b0, 8'h20, 8'h00);
		check("unmapped err", rerr, 1'b1);
		wr(`CTM_OFS_CNT_HI, 8'hFF);
		rdc(`CTM_OFS_CNT_HI, 8'h00);
		// Low byte alone must not reach the live duty value
		wr(`CTM_OFS_DUTY_LO, 8'hA5);
		rdc(`CTM_OFS_DUTY_HI, 8'h00);
		rdc(`CTM_OFS_DUTY_LO, 8'h00);
		wr(`CTM_OFS_DUTY_LO, 8'hA5);
		wr(`CTM_OFS_DUTY_HI, 8'hFE);
		rdc(`CTM_OFS_DUTY_HI, 8'h02);
		rdc(`CTM_OFS_DUTY_LO, 8'hA5);
		// Duty match clears, timer mode, system clock
		wr(`CTM_OFS_DUTY_LO, 8'h0A);
		wr(`CTM_OFS_DUTY_HI, 8'h00);
		restart(8'hC1, 8'h18);
		gap(1, 11);
		wr(`CTM_OFS_CTRL0, 8'h98);
		rdc(`CTM_OFS_CNT_HI, 8'h00);
		bus(1'b0, `CTM_OFS_CNT_LO, 8'h00);
		v1 = rdat;
		check("count bound", v1 <= 32'd10, 1'b1);
		repeat (5) @(posedge clk);
		rdc(`CTM_OFS_CNT_HI, 8'h00);
		rdc(`CTM_OFS_CNT_LO, v1[7:0]);
		// Period match on top three bits, then zero means overflow
		restart(8'hC0, 8'h19);
		gap(0, 129);
		wr(`CTM_OFS_CTRL0, 8'h18);
		gap(0, 1024);
		// External pin, rising then falling; run rising clears count
		wr(`CTM_OFS_DUTY_LO, 8'hFF);
		wr(`CTM_OFS_DUTY_HI, 8'h03);
		restart(8'hC1, 8'h68);
		pulses(5);
		rdc(`CTM_OFS_CNT_HI, 8'h00);
		rdc(`CTM_OFS_CNT_LO, 8'h05);
		restart(8'hC1, 8'h78);
		pulses(3);
		rdc(`CTM_OFS_CNT_HI, 8'h00);
		rdc(`CTM_OFS_CNT_LO, 8'h03);
		// Compare-match output pin actions
		wr(`CTM_OFS_DUTY_LO, 8'h0A);
		wr(`CTM_OFS_DUTY_HI, 8'h00);
		wr(`CTM_OFS_PINCTL, 8'h01);
		restart(8'h21, 8'h18);
		// Reload lands one edge after the run rise is seen
		@(posedge clk);
		check("pin initial", pin, 1'b0);
		check("pin enable", oe, 1'b1);
		watch(20);
		check("pin set", pin, 1'b1);
		restart(8'h19, 8'h18);
		@(posedge clk);
		check("pin initial", pin, 1'b1);
		watch(20);
		check("pin cleared", pin, 1'b0);
		restart(8'h31, 8'h18);
		watch(20);
		watch(44);
		check("toggles", edges, 4);
		restart(8'h25, 8'h18);
		watch(20);
		check("pin inverted", pin, 1'b0);
		restart(8'hC1, 8'h18);
		check("pin enable", oe, 1'b0);
		// PWM: 129-count period, 32 counts active high
		wr(`CTM_OFS_DUTY_LO, 8'h20);
		wr(`CTM_OFS_DUTY_HI, 8'h00);
		restart(8'hA8, 8'h19);
		watch(20);
		watch(258);
		check("pwm high", hits, 64);
		// Slower internal sources: 33 ticks per duty period
		restart(8'hC1, 8'h48);
		gap(1, 132);
		restart(8'hC1, 8'h28);
		gap(1, 1056);
		report_and_stop();
	end
endmodule
